// file: sdgsi_cfg.svh
// Constants for the grouped sigma-delta conversion control block.
// Included by the package and by every design module.
`ifndef SDGSI_CFG_SVH
`define SDGSI_CFG_SVH

`define SDGSI_NCH 3
`define SDGSI_DECIM 32
`define SDGSI_RES_W 16
`define SDGSI_PRE_W 8
`define SDGSI_SET_W 3
`define SDGSI_SETTLE_MAX 3'h4
`define SDGSI_SEL_W 3
`define SDGSI_GAIN_W 3
`define SDGSI_TEMP_SEL 3'h6
`define SDGSI_VEC_W 8
`define SDGSI_VEC_NONE 8'h00
`define SDGSI_VEC_OVF 8'h02
`define SDGSI_VEC_CH0 8'h04
`define SDGSI_VEC_STEP 8'h02

`endif

// file: sdgsi_pkg.sv
// Types shared by the grouped sigma-delta conversion control block.
// Assumes the constants header is on the include path.
`include "sdgsi_cfg.svh"

package sdgsi_pkg;
    // Channel phase: stopped, waiting for the master frame, converting
    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_CONV} sdgsi_phase_e;
    typedef logic [`SDGSI_VEC_W-1:0] sdgsi_vec_t;
endpackage

// file: sdgsi_result_mem.sv
// Result word store, one word per channel, registered read port.
// Assumes all writers and the reader sit on sys_clk.
`timescale 1ns/100ps
`include "sdgsi_cfg.svh"

module sdgsi_result_mem #(
    parameter int W = `SDGSI_RES_W,
    parameter int DEPTH = `SDGSI_NCH,
    parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [DEPTH-1:0] wr_en,
    input wire logic [DEPTH*W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rdata;
    } sdgsi_mem_s;

    sdgsi_mem_s st_reg;
    sdgsi_mem_s st_next;

    // Parallel writes, read of a word written this cycle returns old data
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < DEPTH; i++) begin
            if (wr_en[i]) begin
                st_next.mem[i] = wr_data[i*W +: W];
            end
        end
        if (rd_en && (int'(rd_addr) < DEPTH)) begin
            st_next.rdata = st_reg.mem[rd_addr];
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data = st_reg.rdata;
endmodule // sdgsi_result_mem

// file: sdgsi_chan_timer.sv
// Decimation frame timer of one channel, with one-shot preload stretch.
// Assumes run, start and pre_wr come from logic on sys_clk.
`timescale 1ns/100ps
`include "sdgsi_cfg.svh"

module sdgsi_chan_timer #(
    parameter int DECIM = `SDGSI_DECIM,
    parameter int PRE_W = `SDGSI_PRE_W
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic start,
    input wire logic pre_wr,
    input wire logic [PRE_W-1:0] pre_val,
    output logic conv_done
);
    localparam int CNT_W = $clog2(DECIM + (1 << PRE_W));
    localparam logic [CNT_W-1:0] BASE = CNT_W'(DECIM - 1);

    typedef struct packed {
        logic active;
        logic pend;
        logic [CNT_W-1:0] cnt;
    } sdgsi_tmr_s;

    sdgsi_tmr_s st_reg;
    sdgsi_tmr_s st_next;

    // Frame counting; start never depends on conv_done of this channel
    always_comb begin
        st_next = st_reg;
        conv_done = run && st_reg.active && (st_reg.cnt == '0);
        if (pre_wr) begin
            st_next.pend = 1'b1; // RQ10
        end
        if (!run) begin
            st_next.active = 1'b0;
            st_next.pend = 1'b0;
        end else if (start) begin
            st_next.active = 1'b1;
            st_next.cnt = BASE + CNT_W'(pre_val); // RQ9
            st_next.pend = 1'b0;
        end else if (st_reg.active) begin
            if (st_reg.cnt == '0) begin
                // Stretch only the frame that follows a preload write
                st_next.cnt = st_reg.pend ? BASE + CNT_W'(pre_val) : BASE; // RQ10
                st_next.pend = pre_wr;
            end else begin
                st_next.cnt = st_reg.cnt - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // sdgsi_chan_timer

// file: sdgsi_top.sv
// Grouped sigma-delta conversion control: grouping, start bits, frame
// sync, preload, settle delay, flags and prioritised vector.
// Assumes every input is driven by logic on sys_clk (software side).
// Notes on behaviour
// [RQ1] Link bit joins channel to next higher one
// [RQ2] Master and last channel link read zero
// [RQ3] Master start sets and clears group starts
// [RQ4] Member start clearable alone
// [RQ5] Master clear stops and powers down group
// [RQ6] Continuous mode converts until start clears
// [RQ7] Independently started member waits for master frame
// [RQ8] Result may change when start clears
// [RQ9] Preload lengthens frame by 0 to 255
// [RQ10] Preload applied at start and after write
// [RQ11] Software waits a frame between preload writes
// [RQ12] Resynchronised member gets preload again
// [RQ13] Software keeps master preload at zero
// [RQ14] Code 110 routes temperature sensor, needs reference
// [RQ15] Ready flag on new result, irq needs enables
// [RQ16] Overflow when unread result is overwritten
// [RQ17] Vector shows highest enabled pending source
// [RQ18] Vector access leaves flags alone
// [RQ19] Ready clears on read; overflow by software
// [RQ20] Overflow first, remaining sources re-request
// [RQ21] First irq held off up to four frames
// [RQ22] No irqs for conversions inside settle delay
// [RQ23] Vector codes 0, 2, then 4 upward
// [RQ24] Single mode clears own start when done
`timescale 1ns/100ps
`include "sdgsi_cfg.svh"

module sdgsi_top #(
    parameter int NCH = `SDGSI_NCH,
    parameter int DECIM = `SDGSI_DECIM,
    parameter int RES_W = `SDGSI_RES_W,
    parameter int PRE_W = `SDGSI_PRE_W,
    parameter int CH_W = (NCH > 1) ? $clog2(NCH) : 1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [NCH-1:0] chan_group_link_wr,
    input wire logic [NCH-1:0] single_conv_sel,
    input wire logic [NCH-1:0] start_set_pulse,
    input wire logic [NCH-1:0] start_clr_pulse,
    input wire logic [NCH*PRE_W-1:0] preload_delay_count,
    input wire logic [NCH-1:0] preload_wr_pulse,
    input wire logic [NCH*`SDGSI_SET_W-1:0] irq_settle_delay,
    input wire logic [NCH*`SDGSI_GAIN_W-1:0] gain_sel,
    input wire logic [NCH*`SDGSI_SEL_W-1:0] input_pair_sel,
    input wire logic ref_gen_on,
    input wire logic [NCH*RES_W-1:0] filt_result,
    input wire logic [NCH-1:0] result_irq_en,
    input wire logic ovf_irq_en,
    input wire logic global_irq_en,
    input wire logic [NCH-1:0] ready_clr_pulse,
    input wire logic [NCH-1:0] ovf_clr_pulse,
    input wire logic res_rd_pulse,
    input wire logic [CH_W-1:0] res_rd_ch,
    output logic [NCH-1:0] chan_group_link,
    output logic [NCH-1:0] conv_start_bit,
    output logic [NCH-1:0] chan_power_en,
    output logic [NCH-1:0] result_ready_flag,
    output logic [NCH-1:0] overflow_flag,
    output logic [`SDGSI_VEC_W-1:0] irq_vector_reg,
    output logic irq_req,
    output logic [NCH-1:0] temp_sensor_route,
    output logic temp_ref_missing,
    output logic [RES_W-1:0] res_rd_data,
    output logic res_rd_valid
);
    localparam int SET_W = `SDGSI_SET_W;
    localparam int CFG_W = `SDGSI_GAIN_W + `SDGSI_SEL_W;

    typedef struct packed {
        logic [NCH-1:0] start;
        logic [NCH-1:0] link_rd;
        logic [NCH-1:0] power;
        logic [NCH-1:0] ready;
        logic [NCH-1:0] ovf;
        logic [NCH-1:0] unread;
        logic [NCH-1:0] temp;
        logic temp_err;
        logic irq;
        logic rd_valid;
        sdgsi_pkg::sdgsi_phase_e [NCH-1:0] phase;
        logic [NCH-1:0][SET_W-1:0] settle;
        logic [NCH-1:0][CFG_W-1:0] cfg_prev;
        sdgsi_pkg::sdgsi_vec_t vec;
    } sdgsi_top_s;

    sdgsi_top_s st_reg;
    sdgsi_top_s st_next;
    logic [NCH-1:0] link_eff;
    logic [NCH-1:0] own_go;
    logic [NCH-1:0] mframe;
    logic [NCH-1:0] tmr_start;
    logic [NCH-1:0] conv_done;
    logic [NCH-1:0] mset;
    logic [NCH-1:0] mclr;
    logic [NCH-1:0] settled;

    // Index of the group master: first channel at or above i with link clear
    function automatic int master_of(input logic [NCH-1:0] lk, input int i);
        int m;
        m = i;
        for (int j = 0; j < NCH - 1; j++) begin
            if ((j == m) && lk[j]) begin
                m = j + 1;
            end
        end
        return m;
    endfunction

    // Link bit of the top channel is ignored; masters have link clear
    always_comb begin
        link_eff = chan_group_link_wr;
        link_eff[NCH-1] = 1'b0; // RQ2
    end

    // Frame sync: members start their timer only on a master frame edge
    always_comb begin
        int m;
        m = 0;
        for (int i = 0; i < NCH; i++) begin
            own_go[i] = st_reg.start[i] &&
                (st_reg.phase[i] != sdgsi_pkg::PH_CONV);
            settled[i] = (st_reg.settle[i] == '0);
        end
        for (int i = 0; i < NCH; i++) begin
            m = master_of(link_eff, i); // RQ1
            mframe[i] = own_go[m] || conv_done[m];
            tmr_start[i] = own_go[i] && (!link_eff[i] || mframe[i]); // RQ7
            mset[i] = link_eff[i] && start_set_pulse[m]; // RQ3
            mclr[i] = link_eff[i] && start_clr_pulse[m]; // RQ5
        end
    end

    // One frame timer per channel; restart reloads preload
    for (genvar g = 0; g < NCH; g++) begin : g_tmr
        sdgsi_chan_timer #(
            .DECIM(DECIM),
            .PRE_W(PRE_W)
        ) u_tmr (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .run(st_reg.start[g]),
            .start(tmr_start[g]), // RQ12
            .pre_wr(preload_wr_pulse[g]),
            .pre_val(preload_delay_count[g*PRE_W +: PRE_W]),
            .conv_done(conv_done[g])
        );
    end

    // Results land on each finished frame, also the last one before a stop
    sdgsi_result_mem #(
        .W(RES_W),
        .DEPTH(NCH),
        .AW(CH_W)
    ) u_conv_result_reg (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .wr_en(conv_done), // RQ8
        .wr_data(filt_result),
        .rd_en(res_rd_pulse),
        .rd_addr(res_rd_ch),
        .rd_data(res_rd_data)
    );

    // Start bits, phases, settle counters, flags and vector
    always_comb begin
        logic s;
        logic rdi;
        logic [CFG_W-1:0] cfg;
        logic [SET_W-1:0] dly;
        s = 1'b0;
        rdi = 1'b0;
        cfg = '0;
        dly = '0;
        st_next = st_reg;
        st_next.link_rd = link_eff; // RQ2
        st_next.rd_valid = res_rd_pulse;
        for (int i = 0; i < NCH; i++) begin
            s = st_reg.start[i];
            if (mset[i]) begin
                s = 1'b1; // RQ3
            end
            if (mclr[i]) begin
                s = 1'b0; // RQ5
            end
            // Single mode stops after one frame, continuous keeps going
            if (conv_done[i] && single_conv_sel[i]) begin
                s = 1'b0; // RQ24
            end // RQ6
            if (start_set_pulse[i]) begin
                s = 1'b1;
            end
            if (start_clr_pulse[i]) begin
                s = 1'b0; // RQ4
            end
            st_next.start[i] = s;
            if (!s) begin
                st_next.phase[i] = sdgsi_pkg::PH_IDLE; // RQ5
            end else if (tmr_start[i]) begin
                st_next.phase[i] = sdgsi_pkg::PH_CONV;
            end else if (st_reg.phase[i] == sdgsi_pkg::PH_IDLE) begin
                st_next.phase[i] = sdgsi_pkg::PH_WAIT; // RQ7
            end
            st_next.power[i] = (st_next.phase[i] == sdgsi_pkg::PH_CONV);
            // Settle delay reloads on start rise or gain/input change
            cfg = {gain_sel[i*`SDGSI_GAIN_W +: `SDGSI_GAIN_W],
                   input_pair_sel[i*`SDGSI_SEL_W +: `SDGSI_SEL_W]};
            st_next.cfg_prev[i] = cfg;
            dly = irq_settle_delay[i*SET_W +: SET_W];
            if (dly > `SDGSI_SETTLE_MAX) begin
                dly = `SDGSI_SETTLE_MAX;
            end
            if ((!st_reg.start[i] && s) || (cfg != st_reg.cfg_prev[i])) begin
                st_next.settle[i] = dly; // RQ21
            end else if (conv_done[i] && !settled[i]) begin
                st_next.settle[i] = st_reg.settle[i] - 1'b1;
            end
            // Flags: the hardware set wins over a same-cycle clear
            rdi = res_rd_pulse && (res_rd_ch == CH_W'(i));
            st_next.ready[i] = st_reg.ready[i] && !ready_clr_pulse[i] && !rdi;
            st_next.unread[i] = (st_reg.unread[i] && !rdi) || conv_done[i];
            if (ovf_clr_pulse[i]) begin
                st_next.ovf[i] = 1'b0; // RQ19
            end
            if (conv_done[i] && settled[i]) begin
                st_next.ready[i] = 1'b1; // RQ15
                if (st_reg.unread[i] && !rdi) begin
                    st_next.ovf[i] = 1'b1; // RQ16
                end
            end // RQ22
            st_next.temp[i] = (input_pair_sel[i*`SDGSI_SEL_W +: `SDGSI_SEL_W]
                == `SDGSI_TEMP_SEL); // RQ14
        end
        st_next.temp_err = (|st_next.temp) && !ref_gen_on; // RQ14
        // Vector is a pure function of flags and irq enables, so no access side effects
        st_next.vec = `SDGSI_VEC_NONE; // RQ18
        for (int i = NCH - 1; i >= 0; i--) begin
            if (st_next.ready[i] && result_irq_en[i]) begin
                st_next.vec = `SDGSI_VEC_CH0 +
                    `SDGSI_VEC_STEP * sdgsi_pkg::sdgsi_vec_t'(i); // RQ23
            end
        end // RQ17
        if (ovf_irq_en && (|st_next.ovf)) begin
            st_next.vec = `SDGSI_VEC_OVF; // RQ20
        end
        st_next.irq = global_irq_en && (st_next.vec != `SDGSI_VEC_NONE);
    end

    // State register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign chan_group_link = st_reg.link_rd;
    assign conv_start_bit = st_reg.start;
    assign chan_power_en = st_reg.power;
    assign result_ready_flag = st_reg.ready;
    assign overflow_flag = st_reg.ovf;
    assign irq_vector_reg = st_reg.vec;
    assign irq_req = st_reg.irq;
    assign temp_sensor_route = st_reg.temp;
    assign temp_ref_missing = st_reg.temp_err;
    assign res_rd_valid = st_reg.rd_valid;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    property p_last_link_zero;
        !chan_group_link[NCH-1];
    endproperty
    a_last_link_zero: assert property (p_last_link_zero) // RQ2
        else $error("top channel link bit reads one");

    property p_vec_ovf;
        (|overflow_flag) && $past(ovf_irq_en) |->
            irq_vector_reg == `SDGSI_VEC_OVF;
    endproperty
    a_vec_ovf: assert property (p_vec_ovf) // RQ20
        else $error("overflow not reported first in vector");

    property p_irq_gate;
        irq_req |-> $past(global_irq_en) &&
            (irq_vector_reg != `SDGSI_VEC_NONE);
    endproperty
    a_irq_gate: assert property (p_irq_gate) // RQ15
        else $error("irq raised without enable or source");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        property p_master_set;
            mset[g] && !mclr[g] && !start_clr_pulse[g] &&
                !(conv_done[g] && single_conv_sel[g]) |=> conv_start_bit[g];
        endproperty
        a_master_set: assert property (p_master_set) // RQ3
            else $error("master start did not set member start");

        property p_master_clr;
            mclr[g] && !start_set_pulse[g] |=>
                !conv_start_bit[g] && !chan_power_en[g];
        endproperty
        a_master_clr: assert property (p_master_clr) // RQ5
            else $error("master clear did not stop member");

        property p_indiv_clr;
            start_clr_pulse[g] |=> !conv_start_bit[g];
        endproperty
        a_indiv_clr: assert property (p_indiv_clr) // RQ4
            else $error("software clear of start bit lost");

        property p_single_done;
            conv_done[g] && single_conv_sel[g] && !start_set_pulse[g]
                |=> !conv_start_bit[g];
        endproperty
        a_single_done: assert property (p_single_done) // RQ24
            else $error("single conversion did not clear start");

        property p_member_sync;
            link_eff[g] && tmr_start[g] |->
                tmr_start[master_of(link_eff, g)] ||
                conv_done[master_of(link_eff, g)];
        endproperty
        a_member_sync: assert property (p_member_sync) // RQ7
            else $error("member frame not aligned to master");

        property p_ready_set;
            conv_done[g] && settled[g] |=> result_ready_flag[g];
        endproperty
        a_ready_set: assert property (p_ready_set) // RQ15
            else $error("ready flag missing after result");

        property p_ovf_hold;
            overflow_flag[g] && !ovf_clr_pulse[g] |=> overflow_flag[g];
        endproperty
        a_ovf_hold: assert property (p_ovf_hold) // RQ19
            else $error("overflow flag cleared without software");

        property p_settle_quiet;
            conv_done[g] && !settled[g] && !overflow_flag[g] &&
                !result_ready_flag[g] |=>
                !overflow_flag[g] && !result_ready_flag[g];
        endproperty
        a_settle_quiet: assert property (p_settle_quiet) // RQ22
            else $error("flag raised inside settle delay");
    end
endmodule // sdgsi_top

// file: tb_top.sv
// Self-checking bench for the grouped sigma-delta conversion control.
// Assumes the constants header and the design files are compiled first.
`timescale 1ns/100ps
`include "sdgsi_cfg.svh"

module tb_top;
    localparam int NCH = 3;
    localparam int DECIM = 16;
    localparam int TMAX = 20000;
    logic sys_clk;
    logic arst_n;
    logic [NCH-1:0] link_wr, sngl, st_set, st_clr, pre_wr, rirq_en;
    logic [NCH-1:0] rdy_clr, ovf_clr;
    logic [NCH*8-1:0] pre_cnt;
    logic [NCH*3-1:0] settle, gain, insel;
    logic [NCH*16-1:0] filt;
    logic ref_on, ovf_en, glob, rd_pulse;
    logic [1:0] rd_ch;
    logic [NCH-1:0] grp_link, start_bit, power_en, ready, ovf_flag;
    logic [NCH-1:0] temp_route;
    logic [7:0] vec;
    logic irq, ref_missing, rd_valid;
    logic [15:0] rd_data, cyc, t0, d0, d2;
    int miscompares = 0;
    int cmp_count = 0;

    sdgsi_top #(.DECIM(DECIM)) u_sdgsi_top (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .chan_group_link_wr(link_wr), .single_conv_sel(sngl),
        .start_set_pulse(st_set), .start_clr_pulse(st_clr),
        .preload_delay_count(pre_cnt), .preload_wr_pulse(pre_wr),
        .irq_settle_delay(settle), .gain_sel(gain),
        .input_pair_sel(insel), .ref_gen_on(ref_on), .filt_result(filt),
        .result_irq_en(rirq_en), .ovf_irq_en(ovf_en),
        .global_irq_en(glob), .ready_clr_pulse(rdy_clr),
        .ovf_clr_pulse(ovf_clr), .res_rd_pulse(rd_pulse),
        .res_rd_ch(rd_ch), .chan_group_link(grp_link),
        .conv_start_bit(start_bit), .chan_power_en(power_en),
        .result_ready_flag(ready), .overflow_flag(ovf_flag),
        .irq_vector_reg(vec), .irq_req(irq),
        .temp_sensor_route(temp_route), .temp_ref_missing(ref_missing),
        .res_rd_data(rd_data), .res_rd_valid(rd_valid)
    );

    // Clock at 125 MHz
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    // Filter output carries the cycle number, so a stored result dates it
    always @(posedge sys_clk) begin
        cyc <= cyc + 16'h0001;
        filt <= {3{cyc + 16'h0001}};
        if (cyc == 16'(TMAX)) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
            miscompares++;
        end
    endtask

    // One-cycle pulse: 0 set, 1 clear, 2 preload write, 3 ready, 4 overflow
    task automatic pulse(input int kind, input logic [NCH-1:0] v);
        @(posedge sys_clk);
        t0 = cyc + 16'h0001;
        case (kind)
            0: st_set <= v;
            1: st_clr <= v;
            2: pre_wr <= v;
            3: rdy_clr <= v;
            default: ovf_clr <= v;
        endcase
        @(posedge sys_clk);
        st_set <= '0;
        st_clr <= '0;
        pre_wr <= '0;
        rdy_clr <= '0;
        ovf_clr <= '0;
        #1;
    endtask

    // Result read of one channel
    task automatic rd(input int ch, output logic [15:0] d);
        @(posedge sys_clk);
        rd_pulse <= 1'h1;
        rd_ch <= 2'(ch);
        @(posedge sys_clk);
        rd_pulse <= 1'h0;
        #1;
        d = rd_data;
        check("res_rd_valid", 1'h1, rd_valid);
    endtask

    // Bounded wait for a ready (ovf 0) or overflow (ovf 1) flag
    task automatic wait_flag(input int ovf, input int ch);
        int n;
        n = 0;
        while (((ovf != 0) ? ovf_flag[ch] : ready[ch]) !== 1'h1 && n < 400)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("flag arrives", 1'h1, n < 400);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        arst_n = 1'h0;
        {link_wr, st_set, st_clr, pre_wr, rdy_clr, ovf_clr} = '0;
        {pre_cnt, settle, gain, insel, filt} = '0;
        {ref_on, ovf_en, rd_pulse, rd_ch, cyc} = '0;
        sngl = 3'h7;
        rirq_en = 3'h7;
        glob = 1'h1;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'h1;
        tick(1);
        check("vector at reset", 8'h00, vec);
        check("start at reset", 3'h0, start_bit);
        // Single conversion on each channel alone, every channel vector code
        for (int ch = 0; ch < NCH; ch++) begin
            pulse(0, 3'(1 << ch));
            wait_flag(0, ch);
            check("auto clear", 1'h0, start_bit[ch]);
            check("vector ready", 8'h04 + 8'h02 * ch, vec);
            check("irq_req", 1'h1, irq);
            rd(ch, d0);
            check("frame length", t0 + 1 + DECIM, d0);
            check("ready cleared", 1'h0, ready[ch]);
            tick(1);
            check("vector none", `SDGSI_VEC_NONE, vec);
        end
        @(posedge sys_clk);
        pre_cnt[7:0] <= 8'hff;
        pulse(2, 3'h1);
        pulse(0, 3'h1);
        wait_flag(0, 0);
        rd(0, d0);
        check("preload 255", t0 + 1 + DECIM + 255, d0);
        $display("test single and preload done");
        // Settling delay of two frames in continuous mode
        @(posedge sys_clk);
        pre_cnt[7:0] <= 8'h00;
        sngl <= 3'h6;
        settle[2:0] <= 3'h2;
        pulse(2, 3'h1);
        pulse(0, 3'h1);
        // Between the second suppressed frame and the first flagged one
        tick(2 * DECIM + DECIM / 2);
        check("no overflow in settle", 1'h0, ovf_flag[0]);
        check("no ready in settle", 1'h0, ready[0]);
        wait_flag(0, 0);
        check("overflow after settle", 1'h1, ovf_flag[0]);
        rd(0, d0);
        check("first flagged frame", t0 + 1 + 3 * DECIM, d0);
        pulse(1, 3'h1);
        check("stopped", 1'h0, start_bit[0]);
        $display("test settle done");
        // Temperature sensor selection
        @(posedge sys_clk);
        settle[2:0] <= 3'h0;
        insel[5:3] <= `SDGSI_TEMP_SEL;
        tick(2);
        check("temp route", 3'h2, temp_route);
        check("ref missing", 1'h1, ref_missing);
        @(posedge sys_clk);
        ref_on <= 1'h1;
        tick(2);
        check("ref present", 1'h0, ref_missing);
        check("temp route kept", 3'h2, temp_route);
        @(posedge sys_clk);
        insel[5:3] <= 3'h0;
        $display("test temperature done");
        // Group: ch0 single, ch1 continuous, ch2 master
        @(posedge sys_clk);
        link_wr <= 3'h3;
        sngl <= 3'h1;
        tick(2);
        check("group link", 3'h3, grp_link);
        @(posedge sys_clk);
        link_wr <= 3'h7;
        tick(2);
        check("top link zero", 3'h3, grp_link);
        pulse(0, 3'h4);
        check("group start", 3'h7, start_bit);
        wait_flag(0, 0);
        check("member auto clear", 3'h6, start_bit);
        rd(0, d0);
        rd(2, d2);
        check("group member frame", t0 + 1 + DECIM, d0);
        check("group in step", t0 + 1 + DECIM, d2);
        pulse(1, 3'h2);
        check("member clear", 3'h4, start_bit);
        pulse(3, 3'h7);
        pulse(0, 3'h1);
        wait_flag(0, 0);
        rd(0, d0);
        rd(2, d2);
        check("resync aligned", d2, d0);
        @(posedge sys_clk);
        pre_cnt[7:0] <= 8'h03;
        pulse(2, 3'h1);
        pulse(0, 3'h1);
        wait_flag(0, 0);
        rd(0, d0);
        rd(2, d2);
        check("resync preload", 3, 32'(d0 - d2));
        // Member running beside the master when the master stops
        pulse(0, 3'h2);
        wait_flag(0, 1);
        check("member running", 3'h6, power_en);
        pulse(1, 3'h4);
        check("master stop", 3'h0, start_bit);
        tick(1);
        check("group power down", 3'h0, power_en);
        $display("test group done");
        // Overflow, priority and clearing
        @(posedge sys_clk);
        link_wr <= 3'h0;
        sngl <= 3'h0;
        ovf_en <= 1'h1;
        pulse(3, 3'h7);
        pulse(4, 3'h7);
        pulse(0, 3'h2);
        wait_flag(1, 1);
        check("vector overflow", `SDGSI_VEC_OVF, vec);
        @(posedge sys_clk);
        glob <= 1'h0;
        tick(2);
        check("irq gated", 1'h0, irq);
        @(posedge sys_clk);
        glob <= 1'h1;
        pulse(1, 3'h2);
        @(posedge sys_clk);
        ovf_en <= 1'h0;
        tick(2);
        check("vector masked ovf", 8'h06, vec);
        pulse(3, 3'h2);
        tick(1);
        check("ready cleared sw", 1'h0, ready[1]);
        check("overflow kept", 1'h1, ovf_flag[1]);
        check("vector idle", `SDGSI_VEC_NONE, vec);
        pulse(4, 3'h2);
        check("overflow cleared", 1'h0, ovf_flag[1]);
        $display("test overflow done");
        report_and_stop();
    end
endmodule // tb_top
